// ==== include/alu_consts.svh ====
// Timing counts, field positions and reset values for the datapath.
// Assumes inclusion by bare name from the design files.
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH
`define DATA_W          8
`define ACC_RESET       8'h00
`define TABLE_HIGH_BYTE_RESET      8'h00
`define SKIP_CYCLES     2
`define AUX_BIT         4
`endif

// ==== include/alu_pkg.sv ====
// Types for the rotate/subtract/skip datapath.
// Assumes no surroundings beyond the including modules.
package alu_pkg;
    // Operation codes presented by the sequencer
    typedef enum logic [4:0] {
        OP_NONE, OP_ROTL_C, OP_ROTL_C_ACC, OP_ROTR, OP_ROTR_ACC,
        OP_ROTR_C, OP_ROTR_C_ACC, OP_SUB_BORROW, OP_SUB_BORROW_MEM,
        OP_SUB, OP_SUB_MEM, OP_SUB_IMM, OP_DEC_SKIP, OP_DEC_SKIP_ACC,
        OP_INC_SKIP, OP_INC_SKIP_ACC, OP_SET_BYTE, OP_SET_BIT,
        OP_BIT_NZ_SKIP, OP_BIT_Z_SKIP, OP_ZERO_SKIP, OP_ZERO_MOVE_SKIP,
        OP_SWAP, OP_SWAP_ACC, OP_TBL_CUR, OP_TBL_LAST, OP_XOR, OP_XOR_MEM,
        OP_XOR_IMM
    } op_e;
    // Execution phase, one-hot
    typedef enum logic [1:0] {
        ST_EXEC  = 2'b01,
        ST_DUMMY = 2'b10
    } phase_e;
endpackage

// ==== logic/sub_unit.sv ====
// Eight-bit subtractor with borrow-in and full flag outputs.
// Assumes pure combinational use inside the datapath.
`include "alu_consts.svh"
module sub_unit #(
    parameter int W = `DATA_W
) (
    // Operands
    input  wire logic [W-1:0] minuend,
    input  wire logic [W-1:0] subtrahend,
    input  wire logic         carry_in,
    // Result and flags
    output logic      [W-1:0] diff,
    output logic              carry_out,
    output logic              aux_out,
    output logic              ovf_out
);
    logic [W:0]   full;
    logic [4:0]   low;
    // Carry set means no borrow, as the adder-style flag convention expects
    always_comb begin
        full      = {1'b0, minuend} + {1'b0, ~subtrahend} + {{W{1'b0}}, carry_in};
        low       = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
        diff      = full[W-1:0];
        carry_out = full[W];
        aux_out   = low[4];
        ovf_out   = (minuend[W-1] != subtrahend[W-1]) && (diff[W-1] != minuend[W-1]);
    end
    // Nibble borrow needs a bit above bit 3
    if (W < 5) begin : g_width_check
        $error("sub_unit needs at least five bits");
    end
endmodule

// ==== logic/rot_sub_skip_dp.sv ====
// Execution datapath for rotate, subtract, skip, set, swap, table read and XOR.
// Assumes a sequencer that issues one op with exec_valid and supplies the
// memory byte, immediate and program word in the same cycle.
//
`include "alu_consts.svh"
module rot_sub_skip_dp
    import alu_pkg::*;
#(
    parameter int PC_W  = 12,
    parameter int TBL_W = 8,
    parameter int HI_W  = 7
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // Instruction issue
    input  wire logic              exec_valid,
    input  wire op_e               exec_op,
    input  wire logic [2:0]        bit_sel,
    input  wire logic [7:0]        imm_data,
    input  wire logic [7:0]        mem_rdata,
    input  wire logic [PC_W-1:0]   pc_value,
    input  wire logic [TBL_W-1:0]  table_pointer,
    // Program memory port
    output logic      [PC_W-1:0]   prog_addr,
    input  wire logic [7+HI_W:0]   prog_data,
    // Data memory write port
    output logic                   mem_we,
    output logic      [7:0]        mem_wdata,
    // Sequencer feedback
    output logic                   busy,
    output logic                   skip_next,
    // Architectural state
    output logic      [7:0]        acc_out,
    output logic      [HI_W-1:0]   table_high_byte,
    output logic                   carry_flag,
    output logic                   zero_flag,
    output logic                   aux_carry_flag,
    output logic                   overflow_flag
);
    logic [7:0]      acc_reg;
    logic [HI_W-1:0] table_high_byte_reg;
    logic            c_reg, z_reg, ac_reg, ov_reg;
    logic [7:0]      res_next;
    logic            to_acc, to_mem, upd_sub, upd_z, upd_c, skip_cond, is_skip;
    logic            new_c;
    logic [7:0]      sub_b;
    logic            sub_cin;
    logic [7:0]      sub_d;
    logic            sub_c, sub_ac, sub_ov;
    phase_e          phase_reg;
    logic            mem_we_reg;
    logic [7:0]      mem_wdata_reg;
    logic            skip_reg;

    // Set one bit; used by bit-set and bit tests
    function automatic logic [7:0] bit_mask(input logic [2:0] sel);
        bit_mask = 8'h01 << sel;
    endfunction

    // Refuse widths the page splice and table-high slice cannot serve
    if (PC_W <= TBL_W) begin : g_pc_check
        $error("program counter must be wider than table pointer");
    end
    if (HI_W < 1 || HI_W > 8) begin : g_hi_check
        $error("table high width must be 1 to 8");
    end

    // Subtrahend and borrow selection
    always_comb begin
        sub_b   = (exec_op == OP_SUB_IMM) ? imm_data : mem_rdata;
        sub_cin = (exec_op == OP_SUB_BORROW || exec_op == OP_SUB_BORROW_MEM)
                  ? c_reg : 1'b1;
    end

    sub_unit #(.W(8)) u_sub (
        .minuend    (acc_reg),
        .subtrahend (sub_b),
        .carry_in   (sub_cin),
        .diff       (sub_d),
        .carry_out  (sub_c),
        .aux_out    (sub_ac),
        .ovf_out    (sub_ov)
    );

    // Table address: pointer inside current or last page
    always_comb begin
        if (exec_op == OP_TBL_LAST)
            prog_addr = {{(PC_W-TBL_W){1'b1}}, table_pointer};
        else
            prog_addr = {pc_value[PC_W-1:TBL_W], table_pointer};
    end

    // Result mux and destination decode
    always_comb begin
        res_next  = 8'h00;
        to_acc    = 1'b0;
        to_mem    = 1'b0;
        upd_sub   = 1'b0;
        upd_z     = 1'b0;
        upd_c     = 1'b0;
        new_c     = c_reg;
        is_skip   = 1'b0;
        skip_cond = 1'b0;
        case (exec_op)
            OP_ROTL_C, OP_ROTL_C_ACC: begin
                res_next = {mem_rdata[6:0], c_reg};
                new_c    = mem_rdata[7];
                upd_c    = 1'b1;
                to_mem   = (exec_op == OP_ROTL_C);
                to_acc   = (exec_op == OP_ROTL_C_ACC);
            end
            OP_ROTR, OP_ROTR_ACC: begin
                res_next = {mem_rdata[0], mem_rdata[7:1]};
                to_mem   = (exec_op == OP_ROTR);
                to_acc   = (exec_op == OP_ROTR_ACC);
            end
            OP_ROTR_C, OP_ROTR_C_ACC: begin
                res_next = {c_reg, mem_rdata[7:1]};
                new_c    = mem_rdata[0];
                upd_c    = 1'b1;
                to_mem   = (exec_op == OP_ROTR_C);
                to_acc   = (exec_op == OP_ROTR_C_ACC);
            end
            OP_SUB_BORROW, OP_SUB, OP_SUB_IMM: begin
                res_next = sub_d;
                upd_sub  = 1'b1;
                to_acc   = 1'b1;
            end
            OP_SUB_BORROW_MEM, OP_SUB_MEM: begin
                res_next = sub_d;
                upd_sub  = 1'b1;
                to_mem   = 1'b1;
            end
            OP_DEC_SKIP, OP_DEC_SKIP_ACC: begin
                res_next  = mem_rdata - 8'h01;
                is_skip   = 1'b1;
                skip_cond = (res_next == 8'h00);
                to_mem    = (exec_op == OP_DEC_SKIP);
                to_acc    = (exec_op == OP_DEC_SKIP_ACC);
            end
            OP_INC_SKIP, OP_INC_SKIP_ACC: begin
                res_next  = mem_rdata + 8'h01;
                is_skip   = 1'b1;
                skip_cond = (res_next == 8'h00);
                to_mem    = (exec_op == OP_INC_SKIP);
                to_acc    = (exec_op == OP_INC_SKIP_ACC);
            end
            OP_SET_BYTE: begin
                res_next = 8'hff;
                to_mem   = 1'b1;
            end
            OP_SET_BIT: begin
                res_next = mem_rdata | bit_mask(bit_sel);
                to_mem   = 1'b1;
            end
            OP_BIT_NZ_SKIP: begin
                is_skip   = 1'b1;
                skip_cond = |(mem_rdata & bit_mask(bit_sel));
            end
            OP_BIT_Z_SKIP: begin
                is_skip   = 1'b1;
                skip_cond = ~|(mem_rdata & bit_mask(bit_sel));
            end
            OP_ZERO_SKIP, OP_ZERO_MOVE_SKIP: begin
                res_next  = mem_rdata;
                is_skip   = 1'b1;
                skip_cond = (mem_rdata == 8'h00);
                to_acc    = (exec_op == OP_ZERO_MOVE_SKIP);
            end
            OP_SWAP, OP_SWAP_ACC: begin
                res_next = {mem_rdata[3:0], mem_rdata[7:4]};
                to_mem   = (exec_op == OP_SWAP);
                to_acc   = (exec_op == OP_SWAP_ACC);
            end
            OP_TBL_CUR, OP_TBL_LAST: begin
                res_next = prog_data[7:0];
                to_mem   = 1'b1;
            end
            OP_XOR, OP_XOR_IMM: begin
                res_next = acc_reg ^ ((exec_op == OP_XOR_IMM) ? imm_data : mem_rdata);
                upd_z    = 1'b1;
                to_acc   = 1'b1;
            end
            OP_XOR_MEM: begin
                res_next = acc_reg ^ mem_rdata;
                upd_z    = 1'b1;
                to_mem   = 1'b1;
            end
            default: begin
                res_next = 8'h00;
            end
        endcase
    end

    // An op is accepted only in the execute phase
    logic go;
    assign go = exec_valid && (phase_reg == ST_EXEC);

    // Two-cycle sequencing for skip instructions; dummy slot always inserted
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= ST_EXEC;
        end else begin
            case (phase_reg)
                ST_EXEC:  phase_reg <= (go && is_skip) ? ST_DUMMY : ST_EXEC;
                ST_DUMMY: phase_reg <= ST_EXEC;
                default:  phase_reg <= ST_EXEC;
            endcase
        end
    end

    // Skip decision held through the dummy slot
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            skip_reg <= 1'b0;
        else if (go && is_skip)
            skip_reg <= skip_cond;
        else if (phase_reg == ST_DUMMY)
            skip_reg <= 1'b0;
    end

    // Accumulator update
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            acc_reg <= `ACC_RESET;
        else if (go && to_acc)
            acc_reg <= res_next;
    end

    // Memory write-back, registered one cycle after issue
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_we_reg    <= 1'b0;
            mem_wdata_reg <= 8'h00;
        end else begin
            mem_we_reg    <= go && to_mem;
            mem_wdata_reg <= res_next;
        end
    end

    // Table high part
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            table_high_byte_reg <= HI_W'(`TABLE_HIGH_BYTE_RESET);
        else if (go && (exec_op == OP_TBL_CUR || exec_op == OP_TBL_LAST))
            table_high_byte_reg <= prog_data[7+HI_W:8];
    end

    // Flags; untouched by ops that do not name them
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            c_reg  <= 1'b0;
            z_reg  <= 1'b0;
            ac_reg <= 1'b0;
            ov_reg <= 1'b0;
        end else if (go) begin
            if (upd_sub) begin
                c_reg  <= sub_c;
                ac_reg <= sub_ac;
                ov_reg <= sub_ov;
                z_reg  <= (sub_d == 8'h00);
            end else if (upd_c) begin
                c_reg  <= new_c;
            end else if (upd_z) begin
                z_reg  <= (res_next == 8'h00);
            end
        end
    end

    // Outputs
    assign acc_out         = acc_reg;
    assign table_high_byte = table_high_byte_reg;
    assign carry_flag      = c_reg;
    assign zero_flag       = z_reg;
    assign aux_carry_flag  = ac_reg;
    assign overflow_flag   = ov_reg;
    assign mem_we          = mem_we_reg;
    assign mem_wdata       = mem_wdata_reg;
    assign busy            = (phase_reg == ST_DUMMY);
    assign skip_next       = skip_reg;

    // Skip ops always occupy a dummy cycle
    a_skip_dummy_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
        (go && is_skip) |=> busy ##1 !busy)
        else $error("skip op did not take exactly two cycles");

    // Rotate left through carry to acc
    a_rotl_acc_value: assert property (@(posedge mclk) disable iff (!rst_n)
        (go && exec_op == OP_ROTL_C_ACC) |=>
        acc_reg == {$past(mem_rdata[6:0]), $past(c_reg)} && c_reg == $past(mem_rdata[7]))
        else $error("rotate left through carry wrong");

    // Rotate right through carry to memory
    a_rotr_carry_mem: assert property (@(posedge mclk) disable iff (!rst_n)
        (go && exec_op == OP_ROTR_C) |=>
        mem_we && mem_wdata == {$past(c_reg), $past(mem_rdata[7:1])})
        else $error("rotate right through carry wrong");

    // Subtraction carry means no borrow
    a_sub_carry: assert property (@(posedge mclk) disable iff (!rst_n)
        (go && exec_op == OP_SUB) |=> c_reg == ($past(acc_reg) >= $past(mem_rdata)))
        else $error("subtract carry wrong");

    // Decrement-skip decision
    a_dec_skip: assert property (@(posedge mclk) disable iff (!rst_n)
        (go && exec_op == OP_DEC_SKIP) |=> skip_next == ($past(mem_rdata) == 8'h01))
        else $error("decrement skip decision wrong");

    // Increment-skip leaves flags
    a_inc_noflags: assert property (@(posedge mclk) disable iff (!rst_n)
        (go && exec_op == OP_INC_SKIP_ACC) |=> $stable(c_reg) && $stable(z_reg) && !mem_we)
        else $error("increment skip touched flags or memory");

    // Bit set forces one bit only
    a_bit_set: assert property (@(posedge mclk) disable iff (!rst_n)
        (go && exec_op == OP_SET_BIT) |=>
        mem_wdata == ($past(mem_rdata) | (8'h01 << $past(bit_sel))))
        else $error("bit set wrong");

    // Zero test skip
    a_zero_skip: assert property (@(posedge mclk) disable iff (!rst_n)
        (go && exec_op == OP_ZERO_SKIP) |=> skip_next == ($past(mem_rdata) == 8'h00))
        else $error("zero test skip wrong");

    // XOR updates only zero flag
    a_xor_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        (go && exec_op == OP_XOR) |=> $stable(c_reg) && z_reg == (acc_reg == 8'h00))
        else $error("xor flags wrong");
endmodule

// ==== test/mem_partner.sv ====
// Data byte and program store on the far side of the datapath.
// Assumes the bench preloads the byte one cycle before each issue.
module mem_partner (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Bench preload
    input  wire logic        ld_en,
    input  wire logic [7:0]  ld_data,
    // Data byte
    input  wire logic        mem_we,
    input  wire logic [7:0]  mem_wdata,
    output logic      [7:0]  mem_rdata,
    // Program store
    input  wire logic [11:0] prog_addr,
    output logic      [14:0] prog_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cell_reg;
    // Write-back wins over a preload so a late pulse is never lost
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) cell_reg <= 8'h00;
        else if (mem_we) cell_reg <= mem_wdata;
        else if (ld_en) cell_reg <= ld_data;
    end
    assign mem_rdata = cell_reg;
    // Every address holds a distinct word, so a wrong page shows
    assign prog_data = {prog_addr[6:0] ^ 7'h2a, prog_addr[11:4] ^ prog_addr[7:0]};
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the rotate, subtract and skip datapath.
// Assumes mem_partner supplies the data byte and the program words.
module testbench
    import alu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rst_n, exec_valid, ld_en, mem_we, busy, skip_next;
    logic        carry_flag, zero_flag, aux_carry_flag, overflow_flag;
    op_e         exec_op;
    logic [2:0]  bit_sel;
    logic [7:0]  imm_data, mem_rdata, table_pointer, ld_data, mem_wdata, acc_out, e_acc, e_wd;
    logic [11:0] pc_value, prog_addr;
    logic [14:0] prog_data;
    logic [6:0]  table_high_byte, e_tb;
    logic        e_c, e_z, e_ac, e_ov, e_we, e_sk, e_bz;
    int          failures, checked, cycles, seed, k;
    wire  [3:0]  flags = {carry_flag, zero_flag, aux_carry_flag, overflow_flag};
    logic [7:0]  corner [5] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'hff};
    op_e         follow [4] = '{OP_NONE, OP_SUB_IMM, OP_XOR_IMM, OP_SET_BYTE};

    rot_sub_skip_dp dut_u (.mclk(mclk), .rst_n(rst_n), .exec_valid(exec_valid),
        .exec_op(exec_op), .bit_sel(bit_sel), .imm_data(imm_data), .mem_rdata(mem_rdata),
        .pc_value(pc_value), .table_pointer(table_pointer), .prog_addr(prog_addr),
        .prog_data(prog_data), .mem_we(mem_we), .mem_wdata(mem_wdata), .busy(busy),
        .skip_next(skip_next), .acc_out(acc_out), .table_high_byte(table_high_byte),
        .carry_flag(carry_flag), .zero_flag(zero_flag), .aux_carry_flag(aux_carry_flag),
        .overflow_flag(overflow_flag));
    mem_partner mem_u (.mclk(mclk), .rst_n(rst_n), .ld_en(ld_en), .ld_data(ld_data),
        .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .prog_addr(prog_addr), .prog_data(prog_data));

    // Free-running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Cuts a hang short well above the expected run length
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            failures++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string w);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, w, g, e);
        end
    endtask

    function automatic logic is_skip(input op_e op);
        return op inside {OP_DEC_SKIP, OP_DEC_SKIP_ACC, OP_INC_SKIP, OP_INC_SKIP_ACC,
                          OP_BIT_NZ_SKIP, OP_BIT_Z_SKIP, OP_ZERO_SKIP, OP_ZERO_MOVE_SKIP};
    endfunction

    // Reference step: updates the expected state for one taken op
    task automatic predict(input op_e op, input logic [7:0] m, input logic [7:0] imm,
                           input logic [2:0] b, input logic [11:0] pc, input logic [7:0] tp);
        logic [8:0]  d;
        logic [4:0]  l;
        logic [7:0]  r;
        logic [7:0]  s;
        logic [14:0] w;
        logic        ci;
        logic        tm;
        s = (op == OP_SUB_IMM || op == OP_XOR_IMM) ? imm : m;
        r = 8'h00;
        tm = op inside {OP_ROTL_C, OP_ROTR, OP_ROTR_C, OP_SUB_BORROW_MEM, OP_SUB_MEM,
                        OP_DEC_SKIP, OP_INC_SKIP, OP_SET_BYTE, OP_SET_BIT, OP_SWAP,
                        OP_TBL_CUR, OP_TBL_LAST, OP_XOR_MEM};
        e_sk = 1'b0;
        e_bz = is_skip(op);
        case (op)
            OP_ROTL_C, OP_ROTL_C_ACC: begin
                r = {m[6:0], e_c};
                e_c = m[7];
            end
            OP_ROTR, OP_ROTR_ACC: r = {m[0], m[7:1]};
            OP_ROTR_C, OP_ROTR_C_ACC: begin
                r = {e_c, m[7:1]};
                e_c = m[0];
            end
            OP_SUB_BORROW, OP_SUB_BORROW_MEM, OP_SUB, OP_SUB_MEM, OP_SUB_IMM: begin
                ci = (op == OP_SUB_BORROW || op == OP_SUB_BORROW_MEM) ? e_c : 1'b1;
                d = {1'b0, e_acc} - {1'b0, s} - {8'h00, ~ci};
                l = {1'b0, e_acc[3:0]} - {1'b0, s[3:0]} - {4'h0, ~ci};
                r = d[7:0];
                e_c = ~d[8];
                e_ac = ~l[4];
                e_ov = (e_acc[7] != s[7]) && (r[7] != e_acc[7]);
                e_z = (r == 8'h00);
            end
            OP_DEC_SKIP, OP_DEC_SKIP_ACC: r = m - 8'h01;
            OP_INC_SKIP, OP_INC_SKIP_ACC: r = m + 8'h01;
            OP_SET_BYTE: r = 8'hff;
            OP_SET_BIT: r = m | (8'h01 << b);
            OP_BIT_NZ_SKIP: e_sk = m[b];
            OP_BIT_Z_SKIP: e_sk = !m[b];
            OP_ZERO_MOVE_SKIP, OP_ZERO_SKIP: r = m;
            OP_SWAP, OP_SWAP_ACC: r = {m[3:0], m[7:4]};
            OP_TBL_CUR, OP_TBL_LAST: begin
                w = word({(op == OP_TBL_LAST) ? 4'hf : pc[11:8], tp});
                r = w[7:0];
                e_tb = w[14:8];
            end
            default: begin
                r = e_acc ^ s;
                e_z = (r == 8'h00);
            end
        endcase
        if (op inside {OP_DEC_SKIP, OP_DEC_SKIP_ACC, OP_INC_SKIP, OP_INC_SKIP_ACC, OP_ZERO_SKIP,
                       OP_ZERO_MOVE_SKIP}) e_sk = (r == 8'h00);
        e_we = tm;
        e_wd = r;
        if (!tm && !e_bz || op inside {OP_DEC_SKIP_ACC, OP_INC_SKIP_ACC, OP_ZERO_MOVE_SKIP}) e_acc = r;
    endtask

    function automatic logic [14:0] word(input logic [11:0] a);
        return {a[6:0] ^ 7'h2a, a[11:4] ^ a[7:0]};
    endfunction

    task automatic compare_all;
        chk(acc_out, e_acc, "acc");
        chk({4'h0, flags}, {4'h0, e_c, e_z, e_ac, e_ov}, "flags");
        chk({5'h00, mem_we, busy, skip_next}, {5'h00, e_we, e_bz, e_sk}, "ctl");
        if (e_we) chk(mem_wdata, e_wd, "wdata");
        chk({1'b0, table_high_byte}, {1'b0, e_tb}, "table_high_byte");
    endtask

    task automatic do_reset(input int n);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (n) @(posedge mclk);
        rst_n <= 1'b1;
        {e_acc, e_wd, e_tb, e_c, e_z, e_ac, e_ov, e_we, e_sk, e_bz} = '0;
        #1;
        compare_all();
    endtask

    // Preload, issue, then optionally a second op at the very next edge
    task automatic run_op(input op_e op, input logic [7:0] m, input op_e op2);
        logic [7:0]  imm;
        logic [7:0]  tp;
        logic [2:0]  b;
        logic [11:0] pc;
        imm = 8'($random(seed));
        tp = 8'($random(seed));
        b = 3'($random(seed));
        pc = 12'($random(seed));
        @(posedge mclk);
        ld_en <= 1'b1;
        ld_data <= m;
        @(posedge mclk);
        ld_en <= 1'b0;
        exec_valid <= 1'b1;
        exec_op <= op;
        imm_data <= imm;
        bit_sel <= b;
        pc_value <= pc;
        table_pointer <= tp;
        predict(op, m, imm, b, pc, tp);
        @(posedge mclk);
        exec_valid <= (op2 != OP_NONE);
        exec_op <= op2;
        #1;
        compare_all();
        if (op2 != OP_NONE) begin
            @(posedge mclk);
            exec_valid <= 1'b0;
            if (is_skip(op)) {e_we, e_bz, e_sk} = 3'b000;
            else predict(op2, m, imm, b, pc, tp);
            #1;
            compare_all();
        end
    endtask

    // Corner bytes for every op, then a seeded random mix with a mid-run reset
    initial begin
        seed = 17540;
        {failures, checked} = '0;
        {exec_valid, ld_en, bit_sel, imm_data, ld_data, pc_value, table_pointer} = '0;
        exec_op = OP_NONE;
        rst_n = 1'b0;
        do_reset(4);
        for (int i = 1; i < 29; i++) begin
            foreach (corner[j]) run_op(op_e'(5'(i)), corner[j], OP_NONE);
        end
        run_op(OP_DEC_SKIP, 8'h01, OP_SET_BYTE);
        run_op(OP_XOR_IMM, 8'h3c, OP_SUB_IMM);
        for (int n = 0; n < 400; n++) begin
            if (n == 200) do_reset(2);
            k = $unsigned($random(seed)) % 28;
            run_op(op_e'(5'(k + 1)), 8'($random(seed)), follow[$unsigned($random(seed)) % 4]);
        end
        report_and_stop();
    end
endmodule
